// *** shared/memmap_defines.svh ***
// Address map, register offsets, field positions and boot constants
`ifndef MEMMAP_DEFINES_SVH
`define MEMMAP_DEFINES_SVH
// Low remappable window, 94 kB from zero
`define LOW_END 32'h0001_7800
// Exception vector table top
`define VEC_END 32'h0000_0020
// SRAM, 1536 words of 32 bits
`define SRAM_BASE 32'h0004_0000
`define SRAM_END 32'h0004_1800
`define SRAM_BYTES 32'h0000_1800
`define SRAM_WORDS 1536
// Flash: user part, then the hidden boot kernel part
`define FLASH_BASE 32'h0008_0000
`define FLASH_USER_END 32'h0009_7800
`define FLASH_END 32'h0009_8000
// Peripheral register area, 4 kB
`define MMR_BASE 32'hFFFF_0000
`define MMR_END 32'hFFFF_1000
// Register addresses
`define REMAP_ADDR 32'hFFFF_0220
`define IRQ_STAT_ADDR 32'hFFFF_0240
`define IRQ_EN_ADDR 32'hFFFF_0244
`define IRQ_CLR_ADDR 32'hFFFF_0248
`define BOOT_STAT_ADDR 32'hFFFF_024C
// Field positions
`define REMAP_BIT 0
`define EV_ABORT 0
`define EV_USER 1
`define IRQ_W 2
// Reset values
`define REMAP_RST 1'b0
`define IRQ_RST 2'h0
// Boot check
`define SIG_OFFSET 32'h0000_0014
`define SIG_VALUE 32'h2701_1970
`define PAGE_LAST 7'h7F
`define RESET_VECTOR 32'h0000_0000
`endif

// *** shared/memmap_pkg.sv ***
// Types shared by the memory map decoder and its submodules
package memmap_pkg;
    // Target of one access
    typedef enum logic [1:0] {
        REGION_NONE = 2'b00,
        REGION_SRAM = 2'b01,
        REGION_FLASH = 2'b11,
        REGION_MMR = 2'b10
    } region_e;
    // Access size codes
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'b00,
        SIZE_HALF = 2'b01,
        SIZE_WORD = 2'b10
    } size_e;
    // Boot kernel sequencer, Gray along the path
    typedef enum logic [1:0] {
        BOOT_READ = 2'b00,
        BOOT_SUM = 2'b01,
        BOOT_CHECK = 2'b11,
        BOOT_DONE = 2'b10
    } boot_state_e;
endpackage : memmap_pkg

// *** src/sram_1536x32.sv ***
// On-chip SRAM, 1536 x 32 bits with byte lanes and registered read
`timescale 1ns/10ps
`include "memmap_defines.svh"
module sram_1536x32 (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic we_i,
    input wire logic re_i,
    input wire logic [10:0] idx_i,
    input wire logic [3:0] be_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o
);
    logic [7:0] rdata_q [0:3]; // Read register, one byte per lane

    // One storage array and one read register per byte lane, so that
    // no storage array is written from more than one process
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            logic [7:0] mem_q [0:`SRAM_WORDS-1]; // Storage of this lane
            // Lane write when its enable is set
            always_ff @(posedge clk_i) begin
                if (we_i && be_i[g]) begin
                    mem_q[idx_i] <= wdata_i[8*g +: 8];
                end
            end
            // Lane read when re_i is set, no wait state
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    rdata_q[g] <= 8'h00;
                end else if (re_i) begin
                    rdata_q[g] <= mem_q[idx_i];
                end
            end
        end
    endgenerate
    assign rdata_o = {rdata_q[3], rdata_q[2], rdata_q[1], rdata_q[0]};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Full word written then read back at once
    sequence s_wr_rd;
        we_i && be_i == 4'hF ##1 re_i && !we_i && idx_i == $past(idx_i);
    endsequence
    property p_sram_zero_wait;
        s_wr_rd |=> rdata_o == $past(wdata_i, 2);
    endproperty
    a_sram_zero_wait: assert property (p_sram_zero_wait)
        else $error("SRAM read back wrong");
endmodule : sram_1536x32

// *** src/boot_kernel_check.sv ***
// Boot kernel sequencer: checks page zero signature before user code runs
`timescale 1ns/10ps
`include "memmap_defines.svh"
module boot_kernel_check
    import memmap_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    output logic [6:0] rd_idx_o,
    output logic rd_o,
    input wire logic [31:0] rdata_i,
    output logic done_o,
    output logic download_o,
    output logic start_o
);
    localparam logic [31:0] SIG_OFF = `SIG_OFFSET;
    localparam logic [6:0] SIG_IDX = SIG_OFF[8:2]; // Signature word index
    boot_state_e state_q; // Sequencer state
    logic [6:0] idx_q; // Word being read
    logic [31:0] sum_q; // Page checksum without signature word
    logic [31:0] sig_q; // Captured signature word
    logic done_q; // Kernel finished
    logic dl_q; // Download mode entered
    logic start_q; // Jump to reset vector
    wire sig_ok = (sig_q == `SIG_VALUE) || (sig_q == sum_q);

    // Read page zero word by word, then decide
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= BOOT_READ;
            idx_q <= 7'h0;
            sum_q <= 32'h0;
            sig_q <= 32'h0;
            done_q <= 1'b0;
            dl_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            case (state_q)
                BOOT_READ: begin
                    state_q <= BOOT_SUM;
                end
                BOOT_SUM: begin
                    // Signature word kept apart from the sum
                    if (idx_q == SIG_IDX) begin
                        sig_q <= rdata_i;
                    end else begin
                        sum_q <= sum_q + rdata_i;
                    end
                    if (idx_q == `PAGE_LAST) begin
                        state_q <= BOOT_CHECK;
                    end else begin
                        idx_q <= idx_q + 7'h1;
                        state_q <= BOOT_READ;
                    end
                end
                BOOT_CHECK: begin
                    done_q <= 1'b1;
                    dl_q <= !sig_ok;
                    start_q <= sig_ok;
                    state_q <= BOOT_DONE;
                end
                default: begin
                    start_q <= 1'b0;
                end
            endcase
        end
    end
    assign rd_o = (state_q == BOOT_READ);
    assign rd_idx_o = idx_q;
    assign done_o = done_q;
    assign download_o = dl_q;
    assign start_o = start_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_boot_decide;
        state_q == BOOT_CHECK && sig_q == `SIG_VALUE |=> start_o && !download_o ##1 !start_o;
    endproperty
    a_boot_decide: assert property (p_boot_decide)
        else $error("Valid signature did not start user code");
    property p_boot_reject;
        state_q == BOOT_CHECK && !sig_ok |=> download_o && !start_o;
    endproperty
    a_boot_reject: assert property (p_boot_reject)
        else $error("Bad signature did not enter download mode");
    property p_boot_len;
        $rose(rst_n_i) |-> ##[250:260] done_o;
    endproperty
    a_boot_len: assert property (p_boot_len)
        else $error("Boot kernel did not finish in time");
endmodule : boot_kernel_check

// *** src/memmap_decoder.sv ***
// Memory map decoder with low-region remap, SRAM, flash port and registers
`timescale 1ns/10ps
`include "memmap_defines.svh"
// Summary of operation
// - Four regions: low, SRAM, flash, registers
// - Low 94 kB shows flash, or only 6 kB of SRAM when remapped
// - Undefined addresses raise a data abort
// - Little endian byte order in words
// - SRAM 1536 words at 0x40000
// - SRAM byte, half, word; no waits
// - Flash 94 kB user, 2 kB hidden kernel
// - Vectors at zero served by mapped memory
// - Remap bit 0 selects SRAM at zero
// - Every reset restores flash at zero
// - Kernel runs first, then reset vector
// - Signature or checksum at 0x14 gates user
// - Flash reachable at 0x80000 once the boot kernel is done
module memmap_decoder
    import memmap_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [1:0] size_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic abort_o,
    output logic irq_o,
    output logic [14:0] flash_addr_o,
    output logic flash_rd_o,
    input wire logic [31:0] flash_rdata_i,
    output logic remap_o,
    output logic boot_done_o,
    output logic download_mode_o,
    output logic user_start_o,
    output logic [31:0] start_pc_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // Decode functions

    // Region of one address under the current remap setting
    function automatic region_e region_of(input logic [31:0] a, input logic remap);
        if (a < `LOW_END) begin
            // Low window follows the remap bit
            if (remap) begin
                region_of = (a < `SRAM_BYTES) ? REGION_SRAM : REGION_NONE;
            end else begin
                region_of = REGION_FLASH;
            end
        end else if (a >= `SRAM_BASE && a < `SRAM_END) begin
            region_of = REGION_SRAM;
        end else if (a >= `FLASH_BASE && a < `FLASH_USER_END) begin
            region_of = REGION_FLASH;
        end else if (a >= `MMR_BASE && a < `MMR_END) begin
            region_of = REGION_MMR;
        end else begin
            region_of = REGION_NONE;
        end
    endfunction : region_of

    // Size and alignment check
    function automatic logic misaligned(input logic [1:0] sz, input logic [1:0] a);
        if (sz == SIZE_BYTE) begin
            misaligned = 1'b0;
        end else if (sz == SIZE_HALF) begin
            misaligned = a[0];
        end else if (sz == SIZE_WORD) begin
            misaligned = (a != 2'b00);
        end else begin
            misaligned = 1'b1;
        end
    endfunction : misaligned

    // Byte lanes touched, lowest address in lane 0
    function automatic logic [3:0] lane_en(input logic [1:0] sz, input logic [1:0] a);
        if (sz == SIZE_BYTE) begin
            lane_en = 4'h1 << a;
        end else if (sz == SIZE_HALF) begin
            lane_en = a[1] ? 4'hC : 4'h3;
        end else begin
            lane_en = 4'hF;
        end
    endfunction : lane_en

    ////////////////////////////////////////////////////////////////////////////////
    // State

    logic remap_q; // Remap select bit
    logic [`IRQ_W-1:0] irq_st_q; // Sticky event status
    logic [`IRQ_W-1:0] irq_en_q; // Event enables
    region_e rsel_q; // Region of last read
    logic [1:0] roff_q; // Byte offset of last read
    logic [1:0] rsize_q; // Size of last read
    logic abort_q; // Abort pulse
    logic [31:0] mmr_q; // Register read data
    logic [31:0] sram_q; // SRAM read data
    logic [6:0] boot_idx; // Boot kernel word index
    logic boot_rd; // Boot kernel flash read
    logic boot_done; // Kernel finished
    logic boot_dl; // Download mode
    logic boot_start; // Jump to user reset vector

    ////////////////////////////////////////////////////////////////////////////////
    // Access decode

    wire acc = rd_i | wr_i; // Any request this cycle
    wire region_e region = region_of(addr_i, remap_q);
    wire bad_align = misaligned(size_i, addr_i[1:0]);
    // Refused: during boot, undefined area, bad alignment
    wire bad = acc && (!boot_done || region == REGION_NONE || bad_align);
    wire ok = acc && !bad;
    wire [3:0] be = lane_en(size_i, addr_i[1:0]);
    // Data replicated so each lane holds its own byte
    wire [31:0] wlane = (size_i == SIZE_BYTE) ? {4{wdata_i[7:0]}} :
                        (size_i == SIZE_HALF) ? {2{wdata_i[15:0]}} : wdata_i;
    wire sram_we = ok && wr_i && region == REGION_SRAM;
    wire sram_re = ok && rd_i && region == REGION_SRAM;
    // Low and physical aliases share the offset bits
    wire [10:0] sram_idx = addr_i[12:2];
    wire core_flash_rd = ok && rd_i && region == REGION_FLASH;
    wire mmr_wr = ok && wr_i && region == REGION_MMR;
    wire mmr_rd = ok && rd_i && region == REGION_MMR;
    wire wr_remap = mmr_wr && addr_i == `REMAP_ADDR && be[0];
    wire wr_en = mmr_wr && addr_i == `IRQ_EN_ADDR && be[0];
    wire wr_clr = mmr_wr && addr_i == `IRQ_CLR_ADDR && be[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Flash port, shared with the boot kernel

    // Kernel owns the port until it is done
    assign flash_rd_o = boot_done ? core_flash_rd : boot_rd;
    assign flash_addr_o = boot_done ? addr_i[16:2] : {8'h00, boot_idx};

    ////////////////////////////////////////////////////////////////////////////////
    // Submodules

    sram_1536x32 u_sram (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(sram_we),
        .re_i(sram_re),
        .idx_i(sram_idx),
        .be_i(be),
        .wdata_i(wlane),
        .rdata_o(sram_q)
    );

    boot_kernel_check u_boot (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .rd_idx_o(boot_idx),
        .rd_o(boot_rd),
        .rdata_i(flash_rdata_i),
        .done_o(boot_done),
        .download_o(boot_dl),
        .start_o(boot_start)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    // Events: refused access, user code started
    wire [`IRQ_W-1:0] ev = {boot_start, bad};
    wire [`IRQ_W-1:0] clr = wr_clr ? wlane[`IRQ_W-1:0] : `IRQ_RST;
    // Set wins over a clear in the same cycle
    wire [`IRQ_W-1:0] irq_st_d = (irq_st_q & ~clr) | ev;

    // Remap bit; reserved bits are not stored
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            remap_q <= `REMAP_RST;
        end else if (wr_remap) begin
            remap_q <= wlane[`REMAP_BIT];
        end
    end

    // Interrupt status and enable
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_st_q <= `IRQ_RST;
            irq_en_q <= `IRQ_RST;
        end else begin
            irq_st_q <= irq_st_d;
            if (wr_en) begin
                irq_en_q <= wlane[`IRQ_W-1:0];
            end
        end
    end

    // Register read selection
    wire [31:0] mmr_val =
        (addr_i == `REMAP_ADDR) ? {31'h0, remap_q} :
        (addr_i == `IRQ_STAT_ADDR) ? {30'h0, irq_st_q} :
        (addr_i == `IRQ_EN_ADDR) ? {30'h0, irq_en_q} :
        (addr_i == `BOOT_STAT_ADDR) ? {29'h0, remap_q, boot_dl, boot_done} : 32'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Read pipeline

    // Capture what the answer cycle needs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rsel_q <= REGION_NONE;
            roff_q <= 2'b00;
            rsize_q <= SIZE_WORD;
            abort_q <= 1'b0;
            mmr_q <= 32'h0;
        end else begin
            rsel_q <= (ok && rd_i) ? region : REGION_NONE;
            roff_q <= addr_i[1:0];
            rsize_q <= size_i;
            abort_q <= bad;
            mmr_q <= mmr_rd ? mmr_val : 32'h0;
        end
    end

    // Word from the answering target
    wire [31:0] raw = (rsel_q == REGION_SRAM) ? sram_q :
                      (rsel_q == REGION_FLASH) ? flash_rdata_i :
                      (rsel_q == REGION_MMR) ? mmr_q : 32'h0;
    // Lowest addressed byte moves to bit 0
    wire [31:0] shifted = raw >> {roff_q, 3'b000};
    assign rdata_o = (rsize_q == SIZE_BYTE) ? {24'h0, shifted[7:0]} :
                     (rsize_q == SIZE_HALF) ? {16'h0, shifted[15:0]} : shifted;
    assign abort_o = abort_q;
    assign irq_o = |(irq_st_q & irq_en_q);
    assign remap_o = remap_q;
    assign boot_done_o = boot_done;
    assign download_mode_o = boot_dl;
    assign user_start_o = boot_start;
    assign start_pc_o = `RESET_VECTOR;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_abort_undef;
        acc && boot_done && region_of(addr_i, remap_q) == REGION_NONE |=> abort_o;
    endproperty
    a_abort_undef: assert property (p_abort_undef)
        else $error("Undefined address did not abort");

    property p_kernel_hidden;
        rd_i && boot_done && addr_i >= `FLASH_USER_END && addr_i < `FLASH_END
            |-> !flash_rd_o ##1 abort_o;
    endproperty
    a_kernel_hidden: assert property (p_kernel_hidden)
        else $error("Kernel flash reachable by user access");

    property p_reset_flash;
        $rose(rst_n_i) |-> !remap_o;
    endproperty
    a_reset_flash: assert property (p_reset_flash)
        else $error("Remap not cleared by reset");

    sequence s_remap_wr;
        wr_i && boot_done && addr_i == `REMAP_ADDR && size_i == SIZE_WORD && wdata_i[0];
    endsequence
    sequence s_low_rd;
        rd_i && !wr_i && addr_i < `VEC_END && size_i == SIZE_WORD && addr_i[1:0] == 2'b00;
    endsequence
    property p_remap_next;
        s_remap_wr ##1 s_low_rd |-> !flash_rd_o ##1 !abort_o && rsel_q == REGION_SRAM;
    endproperty
    a_remap_next: assert property (p_remap_next)
        else $error("Remap not effective on next access");

    property p_flash_phys;
        rd_i && boot_done && size_i == SIZE_WORD && addr_i[1:0] == 2'b00 &&
            addr_i >= `FLASH_BASE && addr_i < `FLASH_USER_END
            |-> flash_rd_o && flash_addr_o == addr_i[16:2];
    endproperty
    a_flash_phys: assert property (p_flash_phys)
        else $error("Flash not reachable at physical base");

    property p_low_flash;
        (boot_done && !remap_q) ##0 s_low_rd
            |-> flash_rd_o && flash_addr_o == addr_i[16:2];
    endproperty
    a_low_flash: assert property (p_low_flash)
        else $error("Low region not routed to flash");

    property p_byte_order;
        rd_i && boot_done && size_i == SIZE_BYTE && addr_i == (`SRAM_BASE | 32'h5)
            |=> rdata_o == {24'h0, sram_q[15:8]} && !abort_o;
    endproperty
    a_byte_order: assert property (p_byte_order)
        else $error("Byte lane order wrong");

    property p_abort_status;
        bad |=> irq_st_q[`EV_ABORT];
    endproperty
    a_abort_status: assert property (p_abort_status)
        else $error("Refused access did not set abort status");

    property p_refused_silent;
        bad && wr_i |=> $stable(remap_o);
    endproperty
    a_refused_silent: assert property (p_refused_silent)
        else $error("Refused write changed the remap bit");
endmodule : memmap_decoder

// *** dv/flash_model.sv ***
// Behavioural flash array answering the decoder's word read port
`timescale 1ns/10ps
`include "memmap_defines.svh"
module flash_model (
    input wire logic clk_i,
    input wire logic flash_rd_i,
    input wire logic [14:0] flash_addr_i,
    input wire logic bad_sig_i,
    output logic [31:0] flash_rdata_o
);
    ////////////////////////////////////////////////////////////////////////
    // Word content: boot signature in word 5, index-tagged pattern elsewhere
    // A bad signature word matches neither the constant nor the page sum
    function automatic logic [31:0] word_at(input logic [14:0] idx, input logic bad);
        word_at = (idx == 15'h0005) ? (bad ? 32'h0000_0000 : `SIG_VALUE) :
            {16'hC35A, 1'b0, idx};
    endfunction : word_at

    initial flash_rdata_o = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Answer one cycle after a request; when idle the lines keep toggling
    // so a decoder that samples stale data cannot pass by luck
    always @(posedge clk_i) begin
        if (flash_rd_i) begin
            flash_rdata_o <= word_at(flash_addr_i, bad_sig_i);
        end else begin
            flash_rdata_o <= ~flash_rdata_o;
        end
    end
endmodule : flash_model

// *** dv/tb_memmap_decoder.sv ***
// Self-checking testbench for the memory map decoder
`timescale 1ns/10ps
`include "memmap_defines.svh"
module tb_memmap_decoder import memmap_pkg::*;;
    logic clk_i = 1'b0; // System clock
    logic rst_n_i = 1'b0; // Synchronous reset, active low
    logic wr_i = 1'b0; // Write strobe
    logic rd_i = 1'b0; // Read strobe
    logic [31:0] addr_i = 32'h0;
    logic [31:0] wdata_i = 32'h0;
    logic [1:0] size_i = 2'h0;
    logic [31:0] rdata_o, start_pc_o, flash_rdata_i;
    logic abort_o, irq_o, flash_rd_o, remap_o, boot_done_o, download_mode_o, user_start_o;
    logic [14:0] flash_addr_o;
    logic [31:0] rd_q; // Read data captured by the bus task
    logic ab_q; // Abort captured by the bus task
    logic [31:0] n_start = 32'h0; // Count of user start pulses
    logic bad_sig = 1'b0; // Flash model serves a bad signature
    int n_mismatch = 0;
    int n_tests = 0;
    logic [31:0] bad_a [7] = '{32'h0002_0000, 32'h0001_7800, 32'h0004_1800, 32'h0009_7800,
        32'hFFFF_1000, 32'hFFFE_FFFC, 32'h0004_0001};

    always #10 clk_i = ~clk_i;

    memmap_decoder uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .size_i(size_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .abort_o(abort_o), .irq_o(irq_o), .flash_addr_o(flash_addr_o),
        .flash_rd_o(flash_rd_o), .flash_rdata_i(flash_rdata_i), .remap_o(remap_o),
        .boot_done_o(boot_done_o), .download_mode_o(download_mode_o),
        .user_start_o(user_start_o), .start_pc_o(start_pc_o));

    flash_model flash (.clk_i(clk_i), .flash_rd_i(flash_rd_o),
        .flash_addr_i(flash_addr_o), .bad_sig_i(bad_sig), .flash_rdata_o(flash_rdata_i));

    // Count user start pulses
    always @(posedge clk_i) begin
        if (user_start_o === 1'b1) begin
            n_start <= n_start + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Expected flash word, worked out independently of the model
    function automatic logic [31:0] fw(input logic [14:0] i);
        fw = (i == 15'h0005) ? 32'h2701_1970 : {16'hC35A, 1'b0, i};
    endfunction : fw

    // Compare and report
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One bus cycle; read data and abort are taken in the following cycle
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [1:0] s);
        @(posedge clk_i);
        wr_i <= w;
        rd_i <= ~w;
        addr_i <= a;
        wdata_i <= d;
        size_i <= s;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(negedge clk_i);
        rd_q = rdata_o;
        ab_q = abort_o;
    endtask : acc

    // Read that must complete with a given value
    task automatic rd_chk(input logic [31:0] a, input logic [1:0] s, input logic [31:0] e);
        acc(1'b0, a, 32'h0, s);
        chk("rdata", rd_q, e);
        chk("abort on read", 32'(ab_q), 32'h0);
    endtask : rd_chk

    // Write that must complete
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] s);
        acc(1'b1, a, d, s);
        chk("abort on write", 32'(ab_q), 32'h0);
    endtask : wr

    // Word write followed at once by a word read, no idle cycle between
    task automatic wr_rd(input logic [31:0] wa, input logic [31:0] wd, input logic [31:0] ra,
        input logic [31:0] e);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= wa;
        wdata_i <= wd;
        size_i <= SIZE_WORD;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        addr_i <= ra;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk("back to back rdata", rdata_o, e);
        chk("back to back abort", 32'(abort_o), 32'h0);
    endtask : wr_rd

    // Access that must be refused
    task automatic ab_chk(input logic w, input logic [31:0] a, input logic [1:0] s);
        acc(w, a, 32'h0, s);
        chk("abort", 32'(ab_q), 32'h1);
        chk("rdata on abort", rd_q, 32'h0);
    endtask : ab_chk

    // Reset, a refused early request, then wait for the boot kernel
    task automatic do_reset();
        int k;
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(negedge clk_i);
        chk("remap after reset", 32'(remap_o), 32'h0);
        ab_chk(1'b0, `FLASH_BASE, SIZE_WORD);
        for (k = 0; k < 600 && boot_done_o !== 1'b1; k++) begin
            @(posedge clk_i);
        end
        @(negedge clk_i);
        chk("boot done", 32'(boot_done_o), 32'h1);
    endtask : do_reset

    // Verdict and end of run
    task automatic wrap_up();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////
    // Directed scenarios
    initial begin
        do_reset();
        chk("start pc", start_pc_o, `RESET_VECTOR);
        chk("download", 32'(download_mode_o), 32'h0);
        chk("start pulses", n_start, 32'h1);
        // Flash at zero and at its own base
        rd_chk(32'h0000_0000, SIZE_WORD, fw(15'h0));
        rd_chk(`SIG_OFFSET, SIZE_WORD, `SIG_VALUE);
        rd_chk(32'h0008_0100, SIZE_WORD, fw(15'h0040));
        rd_chk(32'h0009_77FC, SIZE_WORD, fw(15'h5DFF));
        rd_chk(32'h0008_0102, SIZE_HALF, fw(15'h0040) >> 16);
        // SRAM lanes, sizes and bounds
        for (int i = 0; i < 4; i++) begin
            wr(32'h0004_0004 + i, 32'h11 * (i + 1), SIZE_BYTE);
        end
        rd_chk(32'h0004_0004, SIZE_WORD, 32'h4433_2211);
        rd_chk(32'h0004_0006, SIZE_HALF, 32'h0000_4433);
        rd_chk(32'h0004_0005, SIZE_BYTE, 32'h0000_0022);
        wr(32'h0004_0008, 32'h1234_5678, SIZE_WORD);
        wr(32'h0004_000A, 32'h0000_BEEF, SIZE_HALF);
        rd_chk(32'h0004_0008, SIZE_WORD, 32'hBEEF_5678);
        wr(32'h0004_17FC, 32'h5A5A_A5A5, SIZE_WORD);
        rd_chk(32'h0004_17FC, SIZE_WORD, 32'h5A5A_A5A5);
        wr_rd(32'h0004_0010, 32'h0BAD_F00D, 32'h0004_0010, 32'h0BAD_F00D);
        // Undefined places, misalignment, flash writes ignored
        for (int i = 0; i < 7; i++) begin
            ab_chk(1'b0, bad_a[i], SIZE_WORD);
        end
        ab_chk(1'b1, 32'h0002_0000, SIZE_WORD);
        ab_chk(1'b0, 32'h0004_0000, 2'h3);
        wr(`FLASH_BASE, 32'h0, SIZE_WORD);
        rd_chk(`FLASH_BASE, SIZE_WORD, fw(15'h0));
        // Remap to SRAM and back; reserved bits written as zero
        wr(32'h0004_0000, 32'hCAFE_0001, SIZE_WORD);
        wr_rd(`REMAP_ADDR, 32'h0000_0001, 32'h0000_0000, 32'hCAFE_0001);
        chk("remap out", 32'(remap_o), 32'h1);
        rd_chk(`REMAP_ADDR, SIZE_WORD, 32'h1);
        rd_chk(32'h0000_0000, SIZE_WORD, 32'hCAFE_0001);
        rd_chk(32'h0000_0006, SIZE_HALF, 32'h0000_4433);
        ab_chk(1'b0, 32'h0000_1800, SIZE_WORD);
        rd_chk(32'h0008_0100, SIZE_WORD, fw(15'h0040));
        rd_chk(`BOOT_STAT_ADDR, SIZE_WORD, 32'h5);
        wr(`REMAP_ADDR, 32'h0000_0000, SIZE_WORD);
        rd_chk(32'h0000_0004, SIZE_WORD, fw(15'h1));
        // Interrupt: clear, mask, raise, clear
        wr(`IRQ_CLR_ADDR, 32'h3, SIZE_WORD);
        rd_chk(`IRQ_STAT_ADDR, SIZE_WORD, 32'h0);
        ab_chk(1'b0, 32'h0002_0000, SIZE_WORD);
        rd_chk(`IRQ_STAT_ADDR, SIZE_WORD, 32'h1);
        chk("irq masked", 32'(irq_o), 32'h0);
        wr(`IRQ_EN_ADDR, 32'h1, SIZE_WORD);
        rd_chk(`IRQ_EN_ADDR, SIZE_WORD, 32'h1);
        chk("irq raised", 32'(irq_o), 32'h1);
        wr(`IRQ_CLR_ADDR, 32'h1, SIZE_WORD);
        chk("irq cleared", 32'(irq_o), 32'h0);
        rd_chk(`IRQ_CLR_ADDR, SIZE_WORD, 32'h0);
        rd_chk(32'hFFFF_0300, SIZE_WORD, 32'h0);
        // Reset while remapped restores flash at zero
        wr(`REMAP_ADDR, 32'h0000_0001, SIZE_WORD);
        do_reset();
        chk("start pulses", n_start, 32'h2);
        rd_chk(`IRQ_STAT_ADDR, SIZE_WORD, 32'h3);
        rd_chk(32'h0000_0004, SIZE_WORD, fw(15'h1));
        // Reset with a bad signature word enters download mode
        bad_sig <= 1'b1;
        do_reset();
        chk("download", 32'(download_mode_o), 32'h1);
        chk("start pulses", n_start, 32'h2);
        rd_chk(`BOOT_STAT_ADDR, SIZE_WORD, 32'h3);
        wrap_up();
    end
endmodule : tb_memmap_decoder
